// ### hdl/spims_top.sv
// Operation
// - Every byte exchange shifts one byte out and one byte in simultaneously.
// - Master: writing the data buffer starts a transfer; dummy writes fetch slave replies.
// - Data buffer has separate write and read stages; reads return received bytes.
// - Slave: software preloads data buffer; unloaded byte makes the exchange fail.
// - Control bit 7 gates interrupt, bit 6 enables port; both reset to zero.
// - Control bit 4 selects master when one; resets to one.
// - Control bit 3 sets serial clock idle level.
// - Polarity and phase pick data change edge: 00/11 falling, 01/10 rising.
// - Slave samples rising when polarity equals phase, else falling; changes on falling.
// - Control bits 1:0 plus extension bits form rate code, master only.
// - Status bit 7 set at each transfer end, held until software clears; the code does not set it for a slave byte with nothing loaded.
// - Status bit 6 set on data write while transmit FIFO full.
// - Status bits 3 and 2 show transmit FIFO full and empty.
// - Status bits 1 and 0 show receive FIFO full and empty.
// - Data register is an eight-bit read/write buffer without reset value.
// - Rate code 0010 divides by eight; powers of two up to 4096.
// - Extension bits 7:6 hold byte count; done flag set after each byte; the code does not set it for a slave byte with nothing loaded.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none

module spims_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic full,
  output logic empty
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic push;
  logic pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("spims_fifo depth must be a power of two");
  end

  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_comb begin
    push = in_valid && !full;
    pop = out_ready && !empty;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage has no reset value
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule : spims_fifo

module spims_top #(
  parameter int unsigned FIFO_DEPTH = spims_pkg::SPIMS_FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spims_pkg::SPIMS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_n_in,
  output logic ss_n_out,
  output logic irq
);
  import spims_pkg::*;

  // ==========================================================
  // Declarations
  // ==========================================================
  logic [7:0] port_control_reg;
  logic [7:0] port_extension_reg;
  logic transfer_done_flag;
  logic write_collision_flag;
  logic [7:0] next_control;
  logic [7:0] next_ext;
  logic next_done;
  logic next_write_collision_flag;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic apb_setup;
  logic apb_access;
  logic [2:0] sel;
  logic [7:0] status_value;
  logic tx_push;
  logic tx_in_ready;
  logic tx_valid;
  logic tx_pop;
  logic [7:0] tx_data;
  logic tx_fifo_full;
  logic tx_fifo_empty;
  logic rx_push;
  logic rx_ready;
  logic rx_valid;
  logic rx_pop;
  logic [7:0] rx_data;
  logic rx_fifo_full;
  logic rx_fifo_empty;
  logic done_set;
  logic port_enable_bit;
  logic master_select_bit;
  logic clock_idle_level;
  logic clock_phase_sel;
  logic [3:0] rate_code;
  logic [11:0] half_period;
  spims_state_t state;
  spims_state_t next_state;
  logic [11:0] div_cnt;
  logic [11:0] next_div;
  logic [3:0] edge_cnt;
  logic [3:0] next_edge;
  logic sck_level;
  logic next_sck;
  logic [7:0] tx_sh;
  logic [7:0] next_tx;
  logic [7:0] rx_sh;
  logic [7:0] next_rx;
  logic [2:0] bit_cnt;
  logic [2:0] next_bits;
  logic slave_loaded;
  logic next_loaded;
  logic slave_fail;
  logic next_fail;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic [3:0] filt;
  logic [3:0] next_filt;
  logic sck_prev;
  logic s_rise;
  logic s_fall;
  logic s_sample;

  // Address decode, also used by the read mux
  function automatic logic [2:0] spims_decode(input logic [SPIMS_ADDR_W-1:0] addr);
    if (addr == {SPIMS_IDX_CONTROL, 2'b00}) begin
      spims_decode = SPIMS_SEL_CONTROL;
    end else if (addr == {SPIMS_IDX_STATUS, 2'b00}) begin
      spims_decode = SPIMS_SEL_STATUS;
    end else if (addr == {SPIMS_IDX_DATA, 2'b00}) begin
      spims_decode = SPIMS_SEL_DATA;
    end else if (addr == {SPIMS_IDX_EXT, 2'b00}) begin
      spims_decode = SPIMS_SEL_EXT;
    end else begin
      spims_decode = SPIMS_SEL_NONE;
    end
  endfunction : spims_decode

  // Half period in system clocks: divider is two to the power code plus one
  function automatic logic [11:0] spims_half(input logic [3:0] code);
    logic [3:0] c;
    c = (code > SPIMS_RATE_MAX) ? SPIMS_RATE_MAX : code;
    spims_half = 12'h001 << c;
  endfunction : spims_half

  if (FIFO_DEPTH < 2) begin : g_bad_fifo_depth
    $error("spims_top FIFO depth too small");
  end

  assign port_enable_bit = port_control_reg[SPIMS_CTL_ENABLE];
  assign master_select_bit = port_control_reg[SPIMS_CTL_MASTER];
  assign clock_idle_level = port_control_reg[SPIMS_CTL_CLOCK_IDLE_LEVEL];
  assign clock_phase_sel = port_control_reg[SPIMS_CTL_CLOCK_PHASE_SEL];
  assign rate_code = {port_extension_reg[1:0], port_control_reg[1:0]};
  assign half_period = spims_half(rate_code);

  // ==========================================================
  // APB slave and registers
  // ==========================================================
  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable;
  assign pready = 1'b1;
  assign sel = spims_decode(paddr);
  assign status_value = {transfer_done_flag, write_collision_flag, 2'b00,
                         tx_fifo_full, tx_fifo_empty, rx_fifo_full, rx_fifo_empty};
  assign tx_push = apb_access && pwrite && pstrb[0] && (sel == SPIMS_SEL_DATA);
  assign rx_pop = apb_access && !pwrite && (sel == SPIMS_SEL_DATA) && rx_valid;
  assign irq = port_control_reg[SPIMS_CTL_IRQ_EN] && transfer_done_flag;

  always_comb begin
    next_control = port_control_reg;
    next_ext = port_extension_reg;
    next_done = transfer_done_flag;
    next_write_collision_flag = write_collision_flag;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (apb_setup) begin
      next_pslverr = (sel == SPIMS_SEL_NONE);
      if (sel == SPIMS_SEL_CONTROL) begin
        next_prdata = {24'h000000, port_control_reg};
      end else if (sel == SPIMS_SEL_STATUS) begin
        next_prdata = {24'h000000, status_value};
      end else if (sel == SPIMS_SEL_DATA) begin
        next_prdata = {24'h000000, rx_valid ? rx_data : 8'h00};
      end else if (sel == SPIMS_SEL_EXT) begin
        next_prdata = {24'h000000, port_extension_reg};
      end else begin
        next_prdata = 32'h00000000;
      end
    end else begin
      next_pslverr = pslverr && psel;
    end
    if (apb_access && pwrite && pstrb[0]) begin
      if (sel == SPIMS_SEL_CONTROL) begin
        next_control = pwdata[7:0] & SPIMS_CONTROL_MASK;
      end else if (sel == SPIMS_SEL_EXT) begin
        next_ext = pwdata[7:0] & SPIMS_EXT_MASK;
      end else if (sel == SPIMS_SEL_STATUS) begin
        next_done = transfer_done_flag && pwdata[SPIMS_STS_DONE];
        next_write_collision_flag = write_collision_flag && pwdata[SPIMS_STS_WRITE_COLLISION_FLAG];
      end
    end
    // Hardware set wins over a software clear in the same cycle
    if (done_set) begin
      next_done = 1'b1;
    end
    if (tx_push && !tx_in_ready) begin
      next_write_collision_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_control_reg <= SPIMS_CONTROL_RST;
      port_extension_reg <= SPIMS_EXT_RST;
      transfer_done_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      port_control_reg <= next_control;
      port_extension_reg <= next_ext;
      transfer_done_flag <= next_done;
      write_collision_flag <= next_write_collision_flag;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // Transmit and receive FIFOs
  // ==========================================================
  spims_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk(pclk), .rst_n(presetn),
    .in_valid(tx_push), .in_ready(tx_in_ready), .in_data(pwdata[7:0]),
    .out_valid(tx_valid), .out_ready(tx_pop), .out_data(tx_data),
    .full(tx_fifo_full), .empty(tx_fifo_empty)
  );

  spims_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk(pclk), .rst_n(presetn),
    .in_valid(rx_push), .in_ready(rx_ready), .in_data(next_rx),
    .out_valid(rx_valid), .out_ready(rx_pop), .out_data(rx_data),
    .full(rx_fifo_full), .empty(rx_fifo_empty)
  );

  // ==========================================================
  // Pin synchronisers: {sck, mosi, miso, ss_n}
  // ==========================================================
  always_comb begin
    next_filt = filt;
    for (int i = 0; i < 4; i++) begin
      if (sync2[i] == sync3[i]) begin
        next_filt[i] = sync3[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= SPIMS_SYNC_RST;
      sync2 <= SPIMS_SYNC_RST;
      sync3 <= SPIMS_SYNC_RST;
      filt <= SPIMS_SYNC_RST;
      // Same level as the synced clock pin, so no false edge follows reset
      sck_prev <= SPIMS_SYNC_RST[3];
    end else begin
      sync1 <= {sck_in, mosi_in, miso_in, ss_n_in};
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
      sck_prev <= filt[3];
    end
  end

  assign s_rise = filt[3] && !sck_prev;
  assign s_fall = !filt[3] && sck_prev;
  assign s_sample = (clock_idle_level == clock_phase_sel) ? s_rise : s_fall;

  // ==========================================================
  // Serial engine
  // ==========================================================
  always_comb begin
    next_state = state;
    next_div = div_cnt;
    next_edge = edge_cnt;
    next_sck = sck_level;
    next_tx = tx_sh;
    next_rx = rx_sh;
    next_bits = bit_cnt;
    next_loaded = slave_loaded;
    next_fail = slave_fail;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    done_set = 1'b0;
    if (!port_enable_bit) begin
      next_state = SPIMS_IDLE;
      next_sck = clock_idle_level;
      next_bits = 3'h0;
      next_loaded = 1'b0;
    end else if (master_select_bit) begin
      case (state)
        SPIMS_IDLE: begin
          next_sck = clock_idle_level;
          // Waits for room in the receive FIFO before starting a byte
          if (tx_valid && rx_ready) begin
            tx_pop = 1'b1;
            next_tx = tx_data;
            next_div = 12'h000;
            next_edge = 4'h0;
            next_state = SPIMS_RUN;
          end
        end
        SPIMS_RUN: begin
          if (div_cnt == half_period - 12'h001) begin
            next_div = 12'h000;
            next_sck = !sck_level;
            next_edge = edge_cnt + 4'h1;
            if (edge_cnt[0] == clock_phase_sel) begin
              next_rx = {rx_sh[6:0], filt[1]};
            end else if (!(clock_phase_sel && edge_cnt == 4'h0)) begin
              next_tx = {tx_sh[6:0], 1'b0};
            end
            if (edge_cnt == SPIMS_LAST_EDGE) begin
              rx_push = 1'b1;
              done_set = 1'b1;
              next_state = SPIMS_IDLE;
            end
          end else begin
            next_div = div_cnt + 12'h001;
          end
        end
        default: begin
          next_state = SPIMS_IDLE;
        end
      endcase
    end else begin
      next_state = SPIMS_IDLE;
      next_sck = clock_idle_level;
      if (filt[0]) begin
        next_bits = 3'h0;
        next_loaded = 1'b0;
      end else if (!slave_loaded) begin
        next_loaded = 1'b1;
        next_bits = 3'h0;
        if (tx_valid) begin
          tx_pop = 1'b1;
          next_tx = tx_data;
          next_fail = 1'b0;
        end else begin
          next_tx = SPIMS_EMPTY_BYTE;
          next_fail = 1'b1;
        end
      end else begin
        if (s_sample) begin
          next_rx = {rx_sh[6:0], filt[2]};
          next_bits = bit_cnt + 3'h1;
        end
        if (s_fall && (bit_cnt != 3'h0 || s_sample)) begin
          next_tx = {tx_sh[6:0], 1'b0};
        end
        if (s_sample && bit_cnt == SPIMS_LAST_BIT) begin
          next_loaded = 1'b0;
          // A byte that had nothing loaded is discarded
          if (!slave_fail) begin
            rx_push = 1'b1;
            done_set = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SPIMS_IDLE;
      div_cnt <= 12'h000;
      edge_cnt <= 4'h0;
      sck_level <= 1'b0;
      tx_sh <= 8'h00;
      rx_sh <= 8'h00;
      bit_cnt <= 3'h0;
      slave_loaded <= 1'b0;
      slave_fail <= 1'b0;
    end else begin
      state <= next_state;
      div_cnt <= next_div;
      edge_cnt <= next_edge;
      sck_level <= next_sck;
      tx_sh <= next_tx;
      rx_sh <= next_rx;
      bit_cnt <= next_bits;
      slave_loaded <= next_loaded;
      slave_fail <= next_fail;
    end
  end

  assign sck_out = sck_level;
  assign mosi_out = tx_sh[7];
  assign miso_out = tx_sh[7];
  assign sck_oe = port_enable_bit && master_select_bit;
  assign mosi_oe = port_enable_bit && master_select_bit;
  assign miso_oe = port_enable_bit && !master_select_bit && !filt[0];
  assign ss_n_out = !(state == SPIMS_RUN);

  // ==========================================================
  // Assertions
  // ==========================================================
  logic [4:0] tog_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_cnt <= 5'h00;
    end else if (state == SPIMS_IDLE) begin
      tog_cnt <= 5'h00;
    end else if (next_sck != sck_level) begin
      tog_cnt <= tog_cnt + 5'h01;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_irq_on_done: assert property (done_set && port_control_reg[7] |=> irq)
    else $error("interrupt not raised after byte");
  a_disabled_idle: assert property (!port_enable_bit ##1 !port_enable_bit
    |-> state == SPIMS_IDLE && !sck_oe && !miso_oe)
    else $error("disabled port still active");
  a_sck_idle_level: assert property (port_enable_bit && state == SPIMS_IDLE ##1 state == SPIMS_IDLE
    |-> sck_out == $past(clock_idle_level))
    else $error("serial clock idle level wrong");
  a_eight_pulses: assert property ($fell(state == SPIMS_RUN) && $past(port_enable_bit && master_select_bit)
    |-> tog_cnt == 5'h10)
    else $error("byte did not have eight clock pulses");
  a_done_after_byte: assert property ($fell(state == SPIMS_RUN) && $past(port_enable_bit && master_select_bit)
    |-> transfer_done_flag && !rx_fifo_empty)
    else $error("byte end without flag or received byte");
  a_write_collision_flag_set: assert property (tx_push && tx_fifo_full |=> write_collision_flag)
    else $error("write collision not flagged");
  a_write_starts: assert property (tx_push && tx_fifo_empty && rx_ready && state == SPIMS_IDLE
    && port_enable_bit && master_select_bit ##1 port_enable_bit && master_select_bit
    |-> ##[1:2] state == SPIMS_RUN)
    else $error("data write did not start transfer");
  a_data_edge: assert property (state == SPIMS_RUN && $past(state == SPIMS_RUN) && $changed(mosi_out)
    |-> $changed(sck_out) && sck_out == (clock_idle_level ^ clock_phase_sel))
    else $error("data changed on wrong clock edge");
  a_done_sticky: assert property (transfer_done_flag && !(apb_access && pwrite && sel == SPIMS_SEL_STATUS)
    |=> transfer_done_flag)
    else $error("done flag dropped without clear");
  a_empty_status: assert property (apb_setup && sel == SPIMS_SEL_STATUS
    |=> prdata[2] == $past(tx_fifo_empty) && prdata[0] == $past(rx_fifo_empty))
    else $error("status shows wrong fifo state");

  c_master_byte: cover property ($fell(state == SPIMS_RUN));
  c_slave_byte: cover property (done_set && !master_select_bit);
  c_collision: cover property (tx_push && tx_fifo_full);
  c_phase_one: cover property ($fell(state == SPIMS_RUN) && clock_phase_sel);
endmodule : spims_top
`default_nettype wire

// ### hdl/spims_pkg.sv
`default_nettype none
package spims_pkg;
  // ==========================================================
  // Register indices; byte address is four times the index
  // ==========================================================
  localparam int unsigned SPIMS_ADDR_W = 16;
  localparam logic [13:0] SPIMS_IDX_CONTROL = 14'h2540;
  localparam logic [13:0] SPIMS_IDX_STATUS = 14'h2541;
  localparam logic [13:0] SPIMS_IDX_DATA = 14'h2542;
  localparam logic [13:0] SPIMS_IDX_EXT = 14'h2543;
  localparam logic [2:0] SPIMS_SEL_CONTROL = 3'h0;
  localparam logic [2:0] SPIMS_SEL_STATUS = 3'h1;
  localparam logic [2:0] SPIMS_SEL_DATA = 3'h2;
  localparam logic [2:0] SPIMS_SEL_EXT = 3'h3;
  localparam logic [2:0] SPIMS_SEL_NONE = 3'h4;
  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int unsigned SPIMS_CTL_IRQ_EN = 7;
  localparam int unsigned SPIMS_CTL_ENABLE = 6;
  localparam int unsigned SPIMS_CTL_MASTER = 4;
  localparam int unsigned SPIMS_CTL_CLOCK_IDLE_LEVEL = 3;
  localparam int unsigned SPIMS_CTL_CLOCK_PHASE_SEL = 2;
  localparam int unsigned SPIMS_STS_DONE = 7;
  localparam int unsigned SPIMS_STS_WRITE_COLLISION_FLAG = 6;
  // ==========================================================
  // Reset values and counts
  // ==========================================================
  localparam logic [7:0] SPIMS_CONTROL_RST = 8'h10;
  localparam logic [7:0] SPIMS_CONTROL_MASK = 8'hdf;
  localparam logic [7:0] SPIMS_EXT_RST = 8'h02;
  localparam logic [7:0] SPIMS_EXT_MASK = 8'hc3;
  localparam logic [7:0] SPIMS_EMPTY_BYTE = 8'hff;
  localparam logic [3:0] SPIMS_RATE_MAX = 4'hb;
  localparam logic [3:0] SPIMS_LAST_EDGE = 4'hf;
  localparam logic [2:0] SPIMS_LAST_BIT = 3'h7;
  localparam logic [3:0] SPIMS_SYNC_RST = 4'h9;
  localparam int unsigned SPIMS_FIFO_DEPTH = 8;
  typedef enum logic [0:0] {SPIMS_IDLE = 1'b0, SPIMS_RUN = 1'b1} spims_state_t;
endpackage : spims_pkg
`default_nettype wire

// ### dv/spims_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Far-side serial slave
// ==========================================================
module spims_slave_model (
  input wire logic clk,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic idle_level,
  input wire logic phase_sel,
  input wire logic [7:0] reply,
  output logic miso,
  output logic [7:0] got
);
  logic sck_q = 1'b0;
  logic ss_q = 1'b1;
  logic junk = 1'b0;
  logic lead_bit = 1'b0;
  logic [7:0] sh = 8'h00;
  // Deselected line shows a toggling pattern, not a held value
  assign miso = ss_n ? junk : (phase_sel ? lead_bit : sh[7]);
  always @(posedge clk) begin
    sck_q <= sck;
    ss_q <= ss_n;
    junk <= ~junk;
    // Select rises with the last clock edge, so edges are gated by the delayed select
    if (!ss_q && sck != sck_q) begin
      if ((sck_q == idle_level) ^ phase_sel) begin
        got <= {got[6:0], mosi};
      end else if (phase_sel) begin
        lead_bit <= sh[7];
        sh <= {sh[6:0], 1'b0};
      end else begin
        sh <= {sh[6:0], 1'b0};
      end
    end
    if (ss_n) begin
      sh <= reply;
    end
  end
endmodule : spims_slave_model
`default_nettype wire

// ### dv/tb_spims_top.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Bench
// ==========================================================
module tb_spims_top;
  import spims_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sck_out, sck_oe, mosi_out, mosi_oe, miso_in, miso_out, miso_oe, ss_n_out, irq;
  logic idle_level = 1'b0;
  logic phase_sel = 1'b0;
  logic ext_sck = 1'b0;
  logic ext_mosi = 1'b0;
  logic ext_ss_n = 1'b1;
  logic sv;
  logic [7:0] reply = 8'h00;
  logic [7:0] got, rd, tx;
  int err_count = 0;
  int tests_run = 0;
  int edges = 0;
  always #50 pclk = ~pclk;
  always @(sck_out) edges++;
  spims_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sck_in(ext_sck), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(ext_mosi), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_in(miso_in), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ext_ss_n),
    .ss_n_out(ss_n_out), .irq(irq));
  spims_slave_model slave (.clk(pclk), .sck(sck_out), .ss_n(ss_n_out), .mosi(mosi_out),
    .idle_level(idle_level), .phase_sel(phase_sel), .reply(reply), .miso(miso_in), .got(got));
  task results();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  task chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task bus(input logic w, input logic [13:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata[7:0];
    sv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      err_count++;
      results();
    end
  endtask : bus
  task poll(input logic [7:0] mask);
    int n;
    n = 0;
    do begin
      bus(1'b0, SPIMS_IDX_STATUS, 8'h00);
      n++;
    end while ((rd & mask) !== mask && n < 1000);
    if (n >= 1000) begin
      err_count++;
      results();
    end
  endtask : poll
  task t_reset();
    bus(1'b0, SPIMS_IDX_CONTROL, 8'h00);
    chk("control", 8'h10, rd);
    bus(1'b0, SPIMS_IDX_STATUS, 8'h00);
    chk("status", 8'h05, rd);
    chk("irq", 8'h00, {7'h0, irq});
    bus(1'b0, 14'h2544, 8'h00);
    chk("pslverr", 8'h01, {7'h0, sv});
  endtask : t_reset
  task t_modes();
    bus(1'b1, SPIMS_IDX_EXT, 8'h00);
    for (int m = 0; m < 4; m++) begin
      idle_level = m[1];
      phase_sel = m[0];
      tx = {6'h29, m[1:0]};
      reply = {6'h0f, ~m[1:0]};
      bus(1'b1, SPIMS_IDX_CONTROL, {4'hd, m[1:0], 2'h3});
      repeat (2) @(posedge pclk);
      chk("idle clock", {7'h0, idle_level}, {7'h0, sck_out});
      chk("master oe", 8'h06, {5'h0, sck_oe, mosi_oe, miso_oe});
      edges = 0;
      bus(1'b1, SPIMS_IDX_DATA, tx);
      poll(8'h80);
      chk("irq", 8'h01, {7'h0, irq});
      chk("clock toggles", 8'h10, 8'(edges));
      chk("slave got", tx, got);
      bus(1'b0, SPIMS_IDX_DATA, 8'h00);
      chk("rx byte", reply, rd);
      bus(1'b1, SPIMS_IDX_STATUS, 8'h00);
      bus(1'b0, SPIMS_IDX_STATUS, 8'h00);
      chk("done cleared", 8'h05, rd);
      chk("irq cleared", 8'h00, {7'h0, irq});
    end
  endtask : t_modes
  task t_fifo();
    idle_level = 1'b0;
    phase_sel = 1'b0;
    reply = 8'h5a;
    bus(1'b1, SPIMS_IDX_CONTROL, 8'h13);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, SPIMS_IDX_DATA, 8'(i));
    end
    bus(1'b0, SPIMS_IDX_STATUS, 8'h00);
    chk("tx full", 8'h09, rd);
    bus(1'b1, SPIMS_IDX_DATA, 8'hee);
    bus(1'b0, SPIMS_IDX_STATUS, 8'h00);
    chk("collision", 8'h49, rd);
    bus(1'b1, SPIMS_IDX_STATUS, 8'h00);
    bus(1'b1, SPIMS_IDX_CONTROL, 8'h53);
    poll(8'h02);
    chk("rx full", 8'h86, rd);
    chk("irq masked", 8'h00, {7'h0, irq});
    chk("last sent", 8'h07, got);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, SPIMS_IDX_DATA, 8'h00);
      chk("drain", 8'h5a, rd);
    end
    bus(1'b0, SPIMS_IDX_STATUS, 8'h00);
    chk("drained", 8'h85, rd);
  endtask : t_fifo
  // Bench acts as the external master; half period of eight system clocks
  task t_slave(input logic [1:0] md, input logic load);
    logic [7:0] mo;
    logic [7:0] sent;
    mo = 8'h3b;
    sent = 8'h00;
    ext_sck <= md[1];
    bus(1'b1, SPIMS_IDX_STATUS, 8'h00);
    bus(1'b1, SPIMS_IDX_CONTROL, {4'h4, md, 2'h0});
    if (load) begin
      bus(1'b1, SPIMS_IDX_DATA, 8'hc6);
    end
    repeat (6) @(posedge pclk);
    ext_ss_n <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("slave oe", 8'h01, {5'h0, sck_oe, mosi_oe, miso_oe});
    for (int i = 7; i >= 0; i--) begin
      ext_mosi <= mo[i];
      if (md[0]) begin
        ext_sck <= ~md[1];
      end
      repeat (8) @(posedge pclk);
      sent[i] = miso_out;
      ext_sck <= md[0] ? md[1] : ~md[1];
      repeat (8) @(posedge pclk);
      if (!md[0]) begin
        ext_sck <= md[1];
      end
    end
    repeat (8) @(posedge pclk);
    ext_ss_n <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("slave sent", load ? 8'hc6 : 8'hff, sent);
    bus(1'b0, SPIMS_IDX_STATUS, 8'h00);
    chk("slave status", load ? 8'h84 : 8'h05, rd);
    bus(1'b0, SPIMS_IDX_DATA, 8'h00);
    chk("slave rx", load ? 8'h3b : 8'h00, rd);
  endtask : t_slave
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_fifo();
    t_slave(2'b00, 1'b1);
    t_slave(2'b01, 1'b1);
    t_slave(2'b00, 1'b0);
    results();
  end
endmodule : tb_spims_top
`default_nettype wire
